// ### bench/imdu_chk_sva.sv
// Purpose: Port checker for imdu_core
// Assumes: One clock, sync reset
// Notes:   Bound to every imdu_core below the module
`timescale 1ns/10ps
`default_nettype none
module imdu_chk
  import imdu_pkg::*;
(
  input wire logic                 clk_sys,      // Clock
  input wire logic                 rst,          // Reset
  input wire logic                 issue_valid,  // Offer
  input wire imdu_op_e             issue_op,     // Op
  input wire logic [31:0]          first_src,    // Operand 1
  input wire logic [31:0]          second_src,   // Operand 2
  input wire logic [IMDU_RIDX-1:0] issue_dest,   // Dest
  input wire logic                 issue_ready,  // Taken
  input wire logic                 wb_valid,     // Write
  input wire logic [IMDU_RIDX-1:0] wb_dest,      // Write index
  input wire logic [31:0]          wb_data,      // Write data
  input wire logic [31:0]          upper_result, // Upper pair
  input wire logic [31:0]          lower_result  // Lower pair
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Take, product and quotient helpers
  wire logic        tk  = issue_valid && issue_ready;
  wire logic        mv  = issue_op inside {IMDU_OP_MFU, IMDU_OP_MFL};
  wire logic [63:0] prd = {32'h0, first_src} * {32'h0, second_src};
  wire logic [31:0] plo = prd[31:0];
  wire logic [63:0] par = {upper_result, lower_result};
  wire logic [31:0] mvd = (issue_op == IMDU_OP_MFU) ? upper_result : lower_result;
  wire logic        dz  = second_src == 32'h0;
  wire logic [31:0] quo = dz ? 32'h0 : first_src / second_src;
  wire logic [31:0] rem = dz ? 32'h0 : first_src % second_src;
  wire logic        s16 = second_src[31:16] == 16'h0;
  sequence s_div32;
    tk && issue_op == IMDU_OP_DIVU && first_src[31];
  endsequence
  sequence s_div8;
    tk && issue_op == IMDU_OP_DIVU && first_src[31:8] == 24'h0;
  endsequence
  AST_MUL16: assert property (
    tk && issue_op == IMDU_OP_MULTU && s16 |=> (issue_ready || mv) && par == $past(prd))
    else $error("short multiply wrong");
  AST_MUL32: assert property (
    tk && issue_op == IMDU_OP_MULTU && second_src[31:24] != 8'h0
    |=> !issue_ready ##1 par == $past(prd, 2)) else $error("long multiply wrong");
  AST_DIV32_RATE: assert property (
    s_div32 |-> ##31 !issue_ready ##1 (issue_ready || mv)) else $error("divide repeat wrong");
  AST_DIV32_RES: assert property (
    s_div32 |-> ##33 lower_result == $past(quo, 33) && upper_result == $past(rem, 33))
    else $error("divide result wrong");
  AST_DIV8_RATE: assert property (
    s_div8 |-> ##10 !issue_ready ##1 (issue_ready || mv)) else $error("byte divide wrong");
  AST_MOVE: assert property (
    tk && mv |=> wb_valid && wb_dest == $past(issue_dest) && wb_data == $past(mvd))
    else $error("move wrong");
  AST_MUL3: assert property (
    tk && issue_op == IMDU_OP_MUL3 && second_src[31:15] == 17'h0
    |=> wb_valid && wb_data == $past(plo)) else $error("direct multiply wrong");
  AST_MADD: assert property (
    tk && issue_op == IMDU_OP_MADDU && s16 |=> par == $past(par) + $past(prd))
    else $error("accumulate wrong");
  AST_MSUB: assert property (
    tk && issue_op == IMDU_OP_MSUBU && s16 |=> par == $past(par) - $past(prd))
    else $error("subtract wrong");
endmodule
bind imdu_core imdu_chk u_chk (.clk_sys, .rst, .issue_valid, .issue_op, .first_src,
  .second_src, .issue_dest, .issue_ready, .wb_valid, .wb_dest, .wb_data, .upper_result,
  .lower_result);
`default_nettype wire

// ### bench/imdu_rf_model.sv
// Purpose: Register file on the far side of imdu_core
// Assumes: Writes land at the clock edge
// Notes:   Unwritten entries read unknown
`timescale 1ns/10ps
`default_nettype none
module imdu_rf_model
  import imdu_pkg::*;
(
  input  wire logic                 clk_sys,  // Clock
  input  wire logic                 wb_valid, // Write strobe
  input  wire logic [IMDU_RIDX-1:0] wb_dest,  // Write index
  input  wire logic [31:0]          wb_data,  // Write data
  input  wire logic [IMDU_RIDX-1:0] rd_idx,   // Read index
  output logic      [31:0]          rd_data   // Read data
);
  logic [31:0] mem [32];
  // Capture writes
  always_ff @(posedge clk_sys) begin
    if (wb_valid) begin
      mem[wb_dest] <= wb_data;
    end
  end
  assign rd_data = mem[rd_idx];
endmodule
`default_nettype wire

// ### bench/tb_integer_multiply_divide_unit.sv
// Purpose: Self-checking bench for imdu_core
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Pair is read back through moves into the model
`timescale 1ns/10ps
`default_nettype none
module tb_integer_multiply_divide_unit;
  import imdu_pkg::*;
  typedef struct {imdu_op_e op; logic [31:0] a, b, up_e, low_e;} imdu_row_s;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        issue_valid = 1'b0;
  imdu_op_e    issue_op = IMDU_OP_MULT;
  logic [31:0] first_src = 32'h0, second_src = 32'h0, wb_data, upper_result, lower_result;
  logic [4:0]  issue_dest = 5'h0, rd_idx = 5'h0, wb_dest;
  logic        issue_ready, wb_valid;
  logic [31:0] rd_data;
  int          bad_count = 0, check_count = 0;
  imdu_row_s   rows [11] = '{
    '{IMDU_OP_MULTU, 32'h3, 32'h5, 32'h0, 32'hf},
    '{IMDU_OP_MULT, 32'hfffffffe, 32'h7, 32'hffffffff, 32'hfffffff2},
    '{IMDU_OP_MULTU, 32'h100, 32'h01000000, 32'h1, 32'h0},
    '{IMDU_OP_MADDU, 32'h2, 32'h3, 32'h1, 32'h6},
    '{IMDU_OP_MSUBU, 32'h1, 32'h7, 32'h0, 32'hffffffff},
    '{IMDU_OP_MADD, 32'hffffffff, 32'h1, 32'h0, 32'hfffffffe},
    '{IMDU_OP_MSUB, 32'hffffffff, 32'h1, 32'h0, 32'hffffffff},
    '{IMDU_OP_DIVU, 32'h64, 32'h7, 32'h2, 32'he},
    '{IMDU_OP_DIVU, 32'h1234, 32'h0, 32'h0, 32'h0},
    '{IMDU_OP_DIVU, 32'hffffffff, 32'h10, 32'hf, 32'h0fffffff},
    '{IMDU_OP_DIV, 32'hffffff9c, 32'h7, 32'hfffffffe, 32'hfffffff2}};
  always #2.5 clk_sys = ~clk_sys;
  imdu_core dut (.clk_sys, .rst, .issue_valid, .issue_op, .first_src, .second_src,
    .issue_dest, .issue_ready, .wb_valid, .wb_dest, .wb_data, .upper_result, .lower_result);
  imdu_rf_model u_rf (.clk_sys, .wb_valid, .wb_dest, .wb_data, .rd_idx, .rd_data);
  // Compare and verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Offer one operation and hold it until taken
  task automatic issue(input imdu_op_e op, input logic [31:0] a, input logic [31:0] b,
                       input logic [4:0] d);
    int n;
    n = 0;
    issue_valid = 1'b1;
    issue_op = op;
    first_src = a;
    second_src = b;
    issue_dest = d;
    #0.5;
    while (issue_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) begin
      bad_count++;
      report_and_stop();
    end
    @(posedge clk_sys);
    #1;
  endtask
  // Move the pair into registers 1 and 2 and compare
  task automatic chk_pair(input string what, input logic [31:0] up_e, input logic [31:0] low_e);
    issue(IMDU_OP_MFU, 32'h0, 32'h0, 5'h1);
    issue(IMDU_OP_MFL, 32'h0, 32'h0, 5'h2);
    issue_valid = 1'b0;
    @(posedge clk_sys);
    rd_idx = 5'h1;
    #1;
    check({what, " upper"}, rd_data, up_e);
    rd_idx = 5'h2;
    #0.5;
    check({what, " lower"}, rd_data, low_e);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    check("reset ready", {31'h0, issue_ready}, 32'h1);
    check("reset upper", upper_result, 32'h0);
    rst = 1'b0;
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].a, rows[i].b, 5'h0);
      chk_pair("row", rows[i].up_e, rows[i].low_e);
    end
    issue(IMDU_OP_MUL3, 32'h7, 32'h6, 5'h5);
    chk_pair("after direct", 32'hfffffffe, 32'hfffffff2);
    rd_idx = 5'h5;
    #0.5;
    check("direct dest", rd_data, 32'h2a);
    issue(IMDU_OP_MULTU, 32'h2, 32'h2, 5'h0);
    issue(IMDU_OP_MULTU, 32'h3, 32'h3, 5'h0);
    chk_pair("back to back", 32'h0, 32'h9);
    issue(IMDU_OP_DIVU, 32'hffffffff, 32'h3, 5'h0);
    issue_valid = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check("mid reset ready", {31'h0, issue_ready}, 32'h1);
    repeat (40) @(posedge clk_sys);
    #1;
    chk_pair("mid reset", 32'h0, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### verilog/imdu_core.sv
// Purpose: Integer multiply/divide unit with upper/lower result pair
// Assumes: Issue port driven by the pipeline; one operation per accepted cycle
// Notes:   Busy stalls issue; results appear after size-dependent latency
//
// Functional notes
// - 16-bit multiply class ops finish in 1 cycle, issue every cycle.
// - 32-bit multiply class ops finish in 2 cycles, repeat every 2.
// - Divide latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend size.
// - Size comes from second operand for multiply, first for divide.
// - Multiply (other than three-operand) and divide write upper/lower pair, not register file.
// - Moves from upper/lower copy the result register to a destination.
// - Three-operand multiply writes low product word to chosen destination.
// - Multiply-add adds product to the combined upper/lower pair.
// - Multiply-subtract subtracts product from the combined pair.
`timescale 1ns/10ps
`default_nettype none
module imdu_core
  import imdu_pkg::*;
(
  input  wire logic                 clk_sys,      // Core clock
  input  wire logic                 rst,          // Sync reset, active high
  input  wire logic                 issue_valid,  // Operation offered
  input  wire imdu_op_e             issue_op,     // Operation code
  input  wire logic [31:0]          first_src,    // First source operand
  input  wire logic [31:0]          second_src,   // Second source operand
  input  wire logic [IMDU_RIDX-1:0] issue_dest,   // Destination register
  output logic                      issue_ready,  // Operation taken
  output logic                      wb_valid,     // Register file write
  output logic [IMDU_RIDX-1:0]      wb_dest,      // Write index
  output logic [31:0]               wb_data,      // Write data
  output logic [31:0]               upper_result, // Upper result register
  output logic [31:0]               lower_result  // Lower result register
);

  typedef enum logic [1:0] {IMDU_IDLE, IMDU_MUL, IMDU_DIV} imdu_st_e;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  imdu_st_e               st_r, st_nxt;
  logic [IMDU_CW-1:0]     lat_r, lat_nxt;     // Cycles until result
  logic [IMDU_CW-1:0]     rep_r, rep_nxt;     // Cycles until next issue
  logic [31:0]            upper_result_reg, upper_nxt;
  logic [31:0]            lower_result_reg, lower_nxt;
  logic [63:0]            pend_r, pend_nxt;   // Pending result
  logic                   pend3_r, pend3_nxt; // Pending result is MUL3
  logic [IMDU_RIDX-1:0]   dest_r, dest_nxt;
  logic                   wbv_r, wbv_nxt;
  logic [IMDU_RIDX-1:0]   wbd_r, wbd_nxt;
  logic [31:0]            wbx_r, wbx_nxt;

  logic [1:0]             size_cls;
  logic                   sgn;
  logic                   is_mul, is_div, is_move;
  logic [63:0]            prod, acc, divres;
  logic [63:0]            base;               // Pair as the next op sees it
  logic [IMDU_CW-1:0]     lat_sel, rep_sel;

  // Operand size of the relevant source
  imdu_size u_size (
    .operand   ((issue_op == IMDU_OP_DIV || issue_op == IMDU_OP_DIVU) ?
                first_src : second_src),
    .is_signed (sgn),
    .size      (size_cls)
  );

  // ---------------------------------------------------------------
  // Decode and arithmetic
  // ---------------------------------------------------------------
  always_comb begin
    sgn     = issue_op inside {IMDU_OP_MULT, IMDU_OP_MADD, IMDU_OP_MSUB, IMDU_OP_DIV,
                               IMDU_OP_MUL3};
    is_div  = issue_op inside {IMDU_OP_DIV, IMDU_OP_DIVU};
    is_move = issue_op inside {IMDU_OP_MFU, IMDU_OP_MFL};
    is_mul  = !is_div && !is_move;
    if (sgn) begin
      prod = 64'($signed(first_src) * $signed(second_src));
    end else begin
      prod = 64'(first_src * second_src);
    end
    // Forward a result that retires in this very cycle
    if (lat_r == IMDU_CW'(1) && !pend3_r) begin
      base = pend_r;
    end else begin
      base = {upper_result_reg, lower_result_reg};
    end
    if (issue_op inside {IMDU_OP_MADD, IMDU_OP_MADDU}) begin
      acc = base + prod;
    end else if (issue_op inside {IMDU_OP_MSUB, IMDU_OP_MSUBU}) begin
      acc = base - prod;
    end else begin
      acc = prod;
    end
    // Divide: remainder upper, quotient lower; zero divisor gives zero
    if (second_src == 32'h0000_0000) begin
      divres = 64'h0;
    end else if (issue_op == IMDU_OP_DIV) begin
      divres = {32'($signed(first_src) % $signed(second_src)),
                32'($signed(first_src) / $signed(second_src))};
    end else begin
      divres = {first_src % second_src, first_src / second_src};
    end
    if (is_div) begin
      unique case (size_cls)
        2'h0: begin lat_sel = IMDU_CW'(IMDU_DIV8_LAT);  rep_sel = IMDU_CW'(IMDU_DIV8_REP);  end
        2'h1: begin lat_sel = IMDU_CW'(IMDU_DIV16_LAT); rep_sel = IMDU_CW'(IMDU_DIV16_REP); end
        2'h2: begin lat_sel = IMDU_CW'(IMDU_DIV24_LAT); rep_sel = IMDU_CW'(IMDU_DIV24_REP); end
        2'h3: begin lat_sel = IMDU_CW'(IMDU_DIV32_LAT); rep_sel = IMDU_CW'(IMDU_DIV32_REP); end
      endcase
    end else if (size_cls <= 2'h1) begin
      lat_sel = IMDU_CW'(IMDU_MUL16_LAT);
      rep_sel = IMDU_CW'(IMDU_MUL16_REP);
    end else begin
      lat_sel = IMDU_CW'(IMDU_MUL32_LAT);
      rep_sel = IMDU_CW'(IMDU_MUL32_REP);
    end
  end

  // Interlock: moves wait for the result, new ops for the repeat gap
  always_comb begin
    if (is_move) begin
      issue_ready = (lat_r == '0);
    end else begin
      issue_ready = (rep_r == '0);
    end
  end

  // ---------------------------------------------------------------
  // Next-state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    lat_nxt   = (lat_r != '0) ? lat_r - IMDU_CW'(1) : lat_r;
    rep_nxt   = (rep_r != '0) ? rep_r - IMDU_CW'(1) : rep_r;
    upper_nxt = upper_result_reg;
    lower_nxt = lower_result_reg;
    pend_nxt  = pend_r;
    pend3_nxt = pend3_r;
    dest_nxt  = dest_r;
    wbv_nxt   = 1'b0;
    wbd_nxt   = wbd_r;
    wbx_nxt   = wbx_r;
    // Retire pending result when its latency expires
    if (lat_r == IMDU_CW'(1)) begin
      st_nxt = IMDU_IDLE;
      if (pend3_r) begin
        wbv_nxt = 1'b1;
        wbd_nxt = dest_r;
        wbx_nxt = pend_r[31:0];
      end else begin
        upper_nxt = pend_r[63:32];
        lower_nxt = pend_r[31:0];
      end
    end
    if (issue_valid && issue_ready) begin
      if (is_move) begin
        wbv_nxt = 1'b1;
        wbd_nxt = issue_dest;
        wbx_nxt = (issue_op == IMDU_OP_MFU) ? upper_result_reg : lower_result_reg;
      end else begin
        st_nxt    = is_div ? IMDU_DIV : IMDU_MUL;
        rep_nxt   = rep_sel - IMDU_CW'(1);
        pend_nxt  = is_div ? divres : acc;
        pend3_nxt = (issue_op == IMDU_OP_MUL3);
        dest_nxt  = issue_dest;
        if (lat_sel == IMDU_CW'(1)) begin
          // Single-cycle ops land at the take edge itself
          st_nxt  = IMDU_IDLE;
          lat_nxt = '0;
          if (issue_op == IMDU_OP_MUL3) begin
            wbv_nxt = 1'b1;
            wbd_nxt = issue_dest;
            wbx_nxt = acc[31:0];
          end else begin
            upper_nxt = acc[63:32];
            lower_nxt = acc[31:0];
          end
        end else begin
          lat_nxt = lat_sel - IMDU_CW'(1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r             <= IMDU_IDLE;
      lat_r            <= '0;
      rep_r            <= '0;
      upper_result_reg <= IMDU_RES_RST;
      lower_result_reg <= IMDU_RES_RST;
      pend_r           <= 64'h0;
      pend3_r          <= 1'b0;
      dest_r           <= '0;
      wbv_r            <= 1'b0;
      wbd_r            <= '0;
      wbx_r            <= 32'h0;
    end else begin
      st_r             <= st_nxt;
      lat_r            <= lat_nxt;
      rep_r            <= rep_nxt;
      upper_result_reg <= upper_nxt;
      lower_result_reg <= lower_nxt;
      pend_r           <= pend_nxt;
      pend3_r          <= pend3_nxt;
      dest_r           <= dest_nxt;
      wbv_r            <= wbv_nxt;
      wbd_r            <= wbd_nxt;
      wbx_r            <= wbx_nxt;
    end
  end

  // Outputs
  assign wb_valid     = wbv_r;
  assign wb_dest      = wbd_r;
  assign wb_data      = wbx_r;
  assign upper_result = upper_result_reg;
  assign lower_result = lower_result_reg;

endmodule
`default_nettype wire

// ### verilog/imdu_pkg.sv
// Purpose: Constants and types for the integer multiply/divide unit
// Assumes: 32-bit datapath, 5-bit register index
// Notes:   Latency and repeat figures are in core clock cycles
package imdu_pkg;

  localparam int unsigned IMDU_XLEN      = 32;
  localparam int unsigned IMDU_RIDX      = 5;

  // Multiply latency and repeat interval by effective operand size
  localparam int unsigned IMDU_MUL16_LAT = 1;
  localparam int unsigned IMDU_MUL16_REP = 1;
  localparam int unsigned IMDU_MUL32_LAT = 2;
  localparam int unsigned IMDU_MUL32_REP = 2;

  // Divide latency and repeat interval by effective dividend size
  localparam int unsigned IMDU_DIV8_LAT  = 12;
  localparam int unsigned IMDU_DIV8_REP  = 11;
  localparam int unsigned IMDU_DIV16_LAT = 19;
  localparam int unsigned IMDU_DIV16_REP = 18;
  localparam int unsigned IMDU_DIV24_LAT = 26;
  localparam int unsigned IMDU_DIV24_REP = 25;
  localparam int unsigned IMDU_DIV32_LAT = 33;
  localparam int unsigned IMDU_DIV32_REP = 32;

  // Width of the cycle counters
  localparam int unsigned IMDU_CW        = 6;

  // Reset value of the result pair
  localparam logic [31:0] IMDU_RES_RST   = 32'h0000_0000;

  // Operation codes on the issue port
  typedef enum logic [3:0] {
    IMDU_OP_MULT,
    IMDU_OP_MULTU,
    IMDU_OP_MADD,
    IMDU_OP_MADDU,
    IMDU_OP_MSUB,
    IMDU_OP_MSUBU,
    IMDU_OP_DIV,
    IMDU_OP_DIVU,
    IMDU_OP_MUL3,
    IMDU_OP_MFU,
    IMDU_OP_MFL
  } imdu_op_e;

endpackage

// ### verilog/imdu_size.sv
// Purpose: Effective operand size classifier
// Assumes: Operand is 32 bits
// Notes:   Size 0..3 stands for 8, 16, 24, 32 significant bits
`timescale 1ns/10ps
`default_nettype none
module imdu_size
  import imdu_pkg::*;
(
  input  wire logic [31:0] operand,    // Value to classify
  input  wire logic        is_signed,  // Signed interpretation
  output logic      [1:0]  size        // Size class
);

  logic [31:0] mag;

  // Sign bits beyond the class count as extension
  always_comb begin
    mag = (is_signed && operand[31]) ? ~operand : operand;
    if (mag[31:24] != 8'h00) begin
      size = 2'h3;
    end else if (mag[23:16] != 8'h00 || (is_signed && (mag[23] != 1'b0))) begin
      size = 2'h2;
    end else if (mag[15:8] != 8'h00) begin
      size = 2'h1;
    end else begin
      size = 2'h0;
    end
    if (is_signed) begin
      if (mag[31:23] != 9'h000) begin
        size = 2'h3;
      end else if (mag[22:15] != 8'h00) begin
        size = 2'h2;
      end else if (mag[14:7] != 8'h00) begin
        size = 2'h1;
      end else begin
        size = 2'h0;
      end
    end
  end

endmodule
`default_nettype wire
